/* src/fcs_pkg.sv */
package fcs_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int WORD_AW = 8;
	localparam int NUM_BLOCKS = 4;
	localparam int BLK_W = 2;
	localparam int BLK_LSB = 7;
	localparam int BLK_MSB = 8;
	localparam int WORD_LSB = 1;
	localparam int WORD_MSB = 8;
	localparam int BLK_WORDS_W = 6;
	localparam int REG_SEL_BIT = 9;
	localparam int STEP_W = 7;
	localparam int TMR_W = 10;
	localparam int CODE_W = 8;

	localparam logic [ADDR_W-1:0] REG_A_ADDR = 10'h200;
	localparam logic [ADDR_W-1:0] REG_B_ADDR = 10'h202;
	localparam logic [ADDR_W-1:0] WORD_STRIDE = 10'h002;
	localparam logic [1:0] FULL_WORD_BE = 2'h3;
	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

	localparam logic [CODE_W-1:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [CODE_W-1:0] CMD_READ_STATUS = 8'h70;
	localparam logic [CODE_W-1:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [CODE_W-1:0] CMD_PROGRAM = 8'h41;
	localparam logic [CODE_W-1:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [CODE_W-1:0] CMD_LOCK_PROGRAM = 8'h77;
	localparam logic [CODE_W-1:0] CMD_READ_LOCK = 8'h71;
	localparam logic [CODE_W-1:0] CMD_BLANK_CHECK = 8'h25;
	localparam logic [CODE_W-1:0] CMD_CONFIRM = 8'hD0;

	// Control register A and B field positions
	localparam int RA_READY_BIT = 0;
	localparam int RA_REWRITE_EN_BIT = 1;
	localparam int RA_LOCK_DIS_BIT = 2;
	localparam int RA_FLASH_RUN_BIT = 3;
	localparam int RA_PROG_ERR_BIT = 6;
	localparam int RA_ERASE_ERR_BIT = 7;
	localparam int RB_LOCK_RESULT_BIT = 0;
	// Status register byte
	localparam int SR_PROG_BIT = 4;
	localparam int SR_ERASE_BIT = 5;
	localparam int SR_SEQ_BIT = 7;

	// Walk steps inside an operation
	localparam logic [STEP_W-1:0] PROG_CHK_LO = 7'h01;
	localparam logic [STEP_W-1:0] PROG_CHK_HI = 7'h02;
	localparam logic [STEP_W-1:0] PROG_WR_LO = 7'h03;
	localparam logic [STEP_W-1:0] PROG_WR_HI = 7'h04;
	localparam logic [STEP_W-1:0] PROG_LAST = 7'h05;
	localparam logic [STEP_W-1:0] ERASE_LAST = 7'h40;
	localparam logic [STEP_W-1:0] BLANK_LAST = 7'h41;
	localparam logic [STEP_W-1:0] STEP_ONE = 7'h01;

	localparam logic [1:0] RD_PHASE_DATA = 2'h1;
	localparam logic [1:0] RD_PHASE_DONE = 2'h2;

	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 100000;
	localparam int LOCK_TIME_NS = 20000;
	localparam int LOCK_READ_TIME_NS = 1000;
	localparam int BLANK_TIME_NS = 10000;

	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction

	localparam logic [TMR_W-1:0] PROG_CYCLES =
		TMR_W'(ns_to_cycles(PROG_TIME_NS));
	localparam logic [TMR_W-1:0] ERASE_CYCLES =
		TMR_W'(ns_to_cycles(ERASE_TIME_NS));
	localparam logic [TMR_W-1:0] LOCK_CYCLES =
		TMR_W'(ns_to_cycles(LOCK_TIME_NS));
	localparam logic [TMR_W-1:0] LOCK_READ_CYCLES =
		TMR_W'(ns_to_cycles(LOCK_READ_TIME_NS));
	localparam logic [TMR_W-1:0] BLANK_CYCLES =
		TMR_W'(ns_to_cycles(BLANK_TIME_NS));
	localparam logic [TMR_W-1:0] TMR_LAST = 10'h001;
	localparam logic [TMR_W-1:0] TMR_IDLE = 10'h000;

	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_PROG_LO, SEQ_PROG_HI, SEQ_CONFIRM, SEQ_RUN
	} fcs_seq_t;

	typedef enum logic [2:0] {
		OP_NONE, OP_PROGRAM, OP_ERASE, OP_LOCK, OP_LOCK_READ, OP_BLANK
	} fcs_op_t;

	typedef enum logic {RM_ARRAY, RM_STATUS} fcs_rmode_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [1:0] byteenable;
	} fcs_bus_req_t;

	typedef struct packed {
		fcs_seq_t seq;
		fcs_op_t op;
		fcs_rmode_t rmode;
		logic ready;
		logic prog_err;
		logic erase_err;
		logic lock_result;
		logic rewrite_en;
		logic lock_dis;
		logic flash_run;
		logic [NUM_BLOCKS-1:0] lock_bits;
		logic [ADDR_W-1:0] cmd_addr;
		logic [DATA_W-1:0] low_word;
		logic [DATA_W-1:0] high_word;
		logic [STEP_W-1:0] step;
		logic fail;
		logic [1:0] rd_phase;
		logic rd_arr;
		logic [DATA_W-1:0] readdata;
	} fcs_state_t;

	localparam fcs_state_t STATE_RESET = '{
		seq: SEQ_IDLE,
		op: OP_NONE,
		rmode: RM_ARRAY,
		ready: 1'b1,
		prog_err: 1'b0,
		erase_err: 1'b0,
		lock_result: 1'b0,
		rewrite_en: 1'b0,
		lock_dis: 1'b0,
		flash_run: 1'b0,
		lock_bits: 4'hF,
		cmd_addr: 10'h000,
		low_word: 16'h0000,
		high_word: 16'h0000,
		step: 7'h00,
		fail: 1'b0,
		rd_phase: 2'h0,
		rd_arr: 1'b0,
		readdata: 16'h0000
	};

	typedef struct packed {
		logic [TMR_W-1:0] count;
	} fcs_tmr_state_t;
endpackage

/* src/fcs_word_mem.sv */
`timescale 1ns/10ps
module fcs_word_mem (
	input wire logic clk,
	input wire logic [fcs_pkg::WORD_AW-1:0] addr,
	input wire logic we,
	input wire logic [fcs_pkg::DATA_W-1:0] wdata,
	output logic [fcs_pkg::DATA_W-1:0] rdata
);
	// Array contents survive reset, like the nonvolatile cells they stand for
	logic [fcs_pkg::DATA_W-1:0] mem [0:(1<<fcs_pkg::WORD_AW)-1];

	initial begin
		for (int i = 0; i < (1 << fcs_pkg::WORD_AW); i++) begin
			mem[i] = fcs_pkg::ERASED_WORD;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

/* src/fcs_op_timer.sv */
`timescale 1ns/10ps
module fcs_op_timer (
	input wire logic clk,
	input wire logic srst,
	input wire logic load,
	input wire logic [fcs_pkg::TMR_W-1:0] load_value,
	output logic last
);
	fcs_pkg::fcs_tmr_state_t s;
	fcs_pkg::fcs_tmr_state_t n;

	always_comb begin
		n = s;
		if (load) begin
			n.count = load_value;
		end else if (s.count != fcs_pkg::TMR_IDLE) begin
			n.count = s.count - fcs_pkg::TMR_LAST;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s.count <= fcs_pkg::TMR_IDLE;
		end else begin
			s <= n;
		end
	end

	assign last = (s.count == fcs_pkg::TMR_LAST);
endmodule

/* src/fcs_sequencer.sv */
`timescale 1ns/10ps
// Contract
// - Commands are 16-bit writes to even addresses; only the low byte decodes.
// - Code FF selects array reads until another command arrives.
// - After code 70 the next even read returns status on low byte.
// - Code 50 clears program and erase error flags and status copies.
// - Program: 41, low word at same address, high word next; four bytes.
// - Ready flag reads 0 during auto program, 1 after completion.
// - On program completion the program error flag shows program/verify outcome.
// - An already programmed word is never altered before its block erase.
// - RAM-run program start switches reads to status until read array; here a lock read start also restores array reads.
// - Erase: 20 then D0 at block address starts erase and verify.
// - Ready flag reads 0 during block erase, 1 once it finishes.
// - After erase the erase error flag shows erase and verify outcome.
// - RAM-run erase keeps status reads until read array or lock read.
// - Lock program: 77 then D0 at block address clears lock bit.
// - Ready flag shows busy during lock bit program, ready afterwards.
// - Lock read: 71 then D0 loads lock result; read once ready.
// - Blank check: 25 then D0; non-blank reported through erase error.
// - Either error flag set refuses all busy-type commands.
// - Bad second code for erase or lock program sets both errors.
// - Lock result reads 1 for an unlocked block, 0 for locked.
module fcs_sequencer (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic [fcs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [fcs_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [1:0] AVS_BYTEENABLE,
	output logic [fcs_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	fcs_pkg::fcs_state_t s;
	fcs_pkg::fcs_state_t n;
	fcs_pkg::fcs_bus_req_t req;
	logic [fcs_pkg::CODE_W-1:0] code;
	logic [fcs_pkg::BLK_W-1:0] blk;
	logic [fcs_pkg::BLK_W-1:0] wr_blk;
	logic busy;
	logic arr_wr;
	logic reg_wr;
	logic locked;
	logic mem_we;
	logic [fcs_pkg::WORD_AW-1:0] mem_addr;
	logic [fcs_pkg::DATA_W-1:0] mem_wdata;
	logic [fcs_pkg::DATA_W-1:0] mem_rdata;
	logic tmr_load;
	logic [fcs_pkg::TMR_W-1:0] tmr_value;
	logic tmr_last;

	function automatic logic [fcs_pkg::DATA_W-1:0] status_word(
		input fcs_pkg::fcs_state_t st);
		logic [fcs_pkg::DATA_W-1:0] w;
		w = '0;
		w[fcs_pkg::SR_SEQ_BIT] = st.ready;
		w[fcs_pkg::SR_ERASE_BIT] = st.erase_err;
		w[fcs_pkg::SR_PROG_BIT] = st.prog_err;
		return w;
	endfunction

	function automatic logic needs_clean(input logic [7:0] c);
		return c == fcs_pkg::CMD_PROGRAM || c == fcs_pkg::CMD_BLOCK_ERASE ||
			c == fcs_pkg::CMD_LOCK_PROGRAM || c == fcs_pkg::CMD_READ_LOCK ||
			c == fcs_pkg::CMD_BLANK_CHECK;
	endfunction

	function automatic logic [fcs_pkg::TMR_W-1:0] op_cycles(
		input fcs_pkg::fcs_op_t op);
		case (op)
			fcs_pkg::OP_PROGRAM: return fcs_pkg::PROG_CYCLES;
			fcs_pkg::OP_ERASE: return fcs_pkg::ERASE_CYCLES;
			fcs_pkg::OP_LOCK: return fcs_pkg::LOCK_CYCLES;
			fcs_pkg::OP_BLANK: return fcs_pkg::BLANK_CYCLES;
			default: return fcs_pkg::LOCK_READ_CYCLES;
		endcase
	endfunction

	assign req = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS,
		writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};
	assign code = req.writedata[fcs_pkg::CODE_W-1:0];
	assign blk = s.cmd_addr[fcs_pkg::BLK_MSB:fcs_pkg::BLK_LSB];
	assign wr_blk = req.address[fcs_pkg::BLK_MSB:fcs_pkg::BLK_LSB];
	assign busy = (s.seq == fcs_pkg::SEQ_RUN);
	// Odd addresses and partial words never reach the command decoder
	assign arr_wr = req.write && !req.address[fcs_pkg::REG_SEL_BIT] &&
		!req.address[0] && req.byteenable == fcs_pkg::FULL_WORD_BE &&
		s.rewrite_en && !busy;
	assign reg_wr = req.write && req.address == fcs_pkg::REG_A_ADDR &&
		req.byteenable[0];
	assign locked = !s.lock_dis && !s.lock_bits[blk];

	// Writes complete at once; reads wait two cycles for registered data
	assign AVS_WAITREQUEST = req.read && s.rd_phase != fcs_pkg::RD_PHASE_DONE;
	assign AVS_READDATA = s.readdata;

	fcs_word_mem u_mem (
		.clk(REF_CLK),
		.addr(mem_addr),
		.we(mem_we),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	fcs_op_timer u_timer (
		.clk(REF_CLK),
		.srst(SRST),
		.load(tmr_load),
		.load_value(tmr_value),
		.last(tmr_last)
	);

	always_comb begin
		logic start;
		logic seq_err;
		start = 1'b0;
		seq_err = 1'b0;
		n = s;
		mem_we = 1'b0;
		mem_addr = req.address[fcs_pkg::WORD_MSB:fcs_pkg::WORD_LSB];
		mem_wdata = fcs_pkg::ERASED_WORD;
		tmr_load = 1'b0;
		tmr_value = op_cycles(s.op);

		if (reg_wr) begin
			n.rewrite_en = req.writedata[fcs_pkg::RA_REWRITE_EN_BIT];
			n.lock_dis = req.writedata[fcs_pkg::RA_LOCK_DIS_BIT];
			n.flash_run = req.writedata[fcs_pkg::RA_FLASH_RUN_BIT];
		end

		if (arr_wr) begin
			case (s.seq)
				fcs_pkg::SEQ_IDLE: begin
					if (code == fcs_pkg::CMD_READ_ARRAY) begin
						n.rmode = fcs_pkg::RM_ARRAY;
					end else if (code == fcs_pkg::CMD_READ_STATUS) begin
						n.rmode = fcs_pkg::RM_STATUS;
					end else if (code == fcs_pkg::CMD_CLEAR_STATUS) begin
						n.prog_err = 1'b0;
						n.erase_err = 1'b0;
					end else if (needs_clean(code)) begin
						if (!s.prog_err && !s.erase_err) begin
							n.cmd_addr = req.address;
							case (code)
								fcs_pkg::CMD_PROGRAM:
									n.op = fcs_pkg::OP_PROGRAM;
								fcs_pkg::CMD_BLOCK_ERASE:
									n.op = fcs_pkg::OP_ERASE;
								fcs_pkg::CMD_LOCK_PROGRAM:
									n.op = fcs_pkg::OP_LOCK;
								fcs_pkg::CMD_READ_LOCK:
									n.op = fcs_pkg::OP_LOCK_READ;
								default: n.op = fcs_pkg::OP_BLANK;
							endcase
							n.seq = (code == fcs_pkg::CMD_PROGRAM) ?
								fcs_pkg::SEQ_PROG_LO : fcs_pkg::SEQ_CONFIRM;
						end
					end else begin
						seq_err = 1'b1;
					end
				end
				fcs_pkg::SEQ_PROG_LO: begin
					if (req.address == s.cmd_addr) begin
						n.low_word = req.writedata;
						n.seq = fcs_pkg::SEQ_PROG_HI;
					end else begin
						seq_err = 1'b1;
					end
				end
				fcs_pkg::SEQ_PROG_HI: begin
					if (req.address == s.cmd_addr + fcs_pkg::WORD_STRIDE) begin
						n.high_word = req.writedata;
						start = 1'b1;
					end else begin
						seq_err = 1'b1;
					end
				end
				fcs_pkg::SEQ_CONFIRM: begin
					if (code == fcs_pkg::CMD_CONFIRM) begin
						if (s.op == fcs_pkg::OP_LOCK &&
							req.address != s.cmd_addr) begin
							seq_err = 1'b1;
						end else begin
							n.cmd_addr = req.address;
							start = 1'b1;
						end
					end else if (code == fcs_pkg::CMD_READ_ARRAY) begin
						n.rmode = fcs_pkg::RM_ARRAY;
						n.op = fcs_pkg::OP_NONE;
						n.seq = fcs_pkg::SEQ_IDLE;
					end else if (s.op == fcs_pkg::OP_ERASE ||
						s.op == fcs_pkg::OP_LOCK) begin
						seq_err = 1'b1;
					end else begin
						n.op = fcs_pkg::OP_NONE;
						n.seq = fcs_pkg::SEQ_IDLE;
					end
				end
				default: n.seq = fcs_pkg::SEQ_IDLE;
			endcase
		end

		if (seq_err) begin
			n.prog_err = 1'b1;
			n.erase_err = 1'b1;
			n.op = fcs_pkg::OP_NONE;
			n.seq = fcs_pkg::SEQ_IDLE;
		end

		if (start) begin
			n.seq = fcs_pkg::SEQ_RUN;
			n.ready = 1'b0;
			n.step = '0;
			n.fail = 1'b0;
			tmr_load = 1'b1;
			// Flash-run software keeps executing from the array, so it
			// must keep array reads; only RAM-run flips to status
			if (!s.flash_run && s.op != fcs_pkg::OP_LOCK_READ) begin
				n.rmode = fcs_pkg::RM_STATUS;
			end
			if (s.op == fcs_pkg::OP_LOCK_READ) begin
				n.rmode = fcs_pkg::RM_ARRAY;
			end
		end

		if (busy) begin
			case (s.op)
				fcs_pkg::OP_PROGRAM: begin
					mem_addr = (s.step == fcs_pkg::STEP_ONE ||
						s.step == fcs_pkg::PROG_WR_HI) ?
						s.cmd_addr[fcs_pkg::WORD_MSB:fcs_pkg::WORD_LSB] +
						fcs_pkg::WORD_AW'(1) :
						s.cmd_addr[fcs_pkg::WORD_MSB:fcs_pkg::WORD_LSB];
					// Only erased words may be written; anything else fails
					if ((s.step == fcs_pkg::PROG_CHK_LO ||
						s.step == fcs_pkg::PROG_CHK_HI) &&
						mem_rdata != fcs_pkg::ERASED_WORD) begin
						n.fail = 1'b1;
					end
					if (locked) begin
						n.fail = 1'b1;
					end
					if (s.step == fcs_pkg::PROG_WR_LO) begin
						mem_we = !s.fail;
						mem_wdata = s.low_word;
					end
					if (s.step == fcs_pkg::PROG_WR_HI) begin
						mem_we = !s.fail;
						mem_wdata = s.high_word;
					end
					if (s.step != fcs_pkg::PROG_LAST) begin
						n.step = s.step + fcs_pkg::STEP_ONE;
					end
				end
				fcs_pkg::OP_ERASE: begin
					mem_addr = {blk, s.step[fcs_pkg::BLK_WORDS_W-1:0]};
					n.fail = locked;
					if (s.step != fcs_pkg::ERASE_LAST) begin
						mem_we = !locked;
						n.step = s.step + fcs_pkg::STEP_ONE;
					end
				end
				fcs_pkg::OP_BLANK: begin
					mem_addr = {blk, s.step[fcs_pkg::BLK_WORDS_W-1:0]};
					// Lock bit is judged without the lock-disable override
					if (!s.lock_bits[blk]) begin
						n.fail = 1'b1;
					end
					if (s.step != '0 && mem_rdata != fcs_pkg::ERASED_WORD) begin
						n.fail = 1'b1;
					end
					if (s.step != fcs_pkg::BLANK_LAST) begin
						n.step = s.step + fcs_pkg::STEP_ONE;
					end
				end
				default: begin
					n.step = s.step;
				end
			endcase

			if (tmr_last) begin
				n.ready = 1'b1;
				n.seq = fcs_pkg::SEQ_IDLE;
				n.op = fcs_pkg::OP_NONE;
				case (s.op)
					fcs_pkg::OP_PROGRAM: n.prog_err = n.fail;
					fcs_pkg::OP_ERASE: begin
						n.erase_err = n.fail;
						if (!n.fail) begin
							n.lock_bits[blk] = 1'b1;
						end
					end
					fcs_pkg::OP_BLANK: n.erase_err = n.fail;
					fcs_pkg::OP_LOCK: n.lock_bits[blk] = 1'b0;
					fcs_pkg::OP_LOCK_READ:
						n.lock_result = s.lock_bits[blk];
					default: n.op = fcs_pkg::OP_NONE;
				endcase
			end
		end

		// Read pipeline: phase 0 addresses memory, phase 1 builds the word
		if (req.read) begin
			if (s.rd_phase == fcs_pkg::RD_PHASE_DONE) begin
				n.rd_phase = '0;
			end else begin
				n.rd_phase = s.rd_phase + 2'h1;
			end
			if (s.rd_phase == '0) begin
				n.rd_arr = !busy;
			end
			if (s.rd_phase == fcs_pkg::RD_PHASE_DATA) begin
				n.readdata = '0;
				if (req.address == fcs_pkg::REG_A_ADDR) begin
					n.readdata[fcs_pkg::RA_READY_BIT] = s.ready;
					n.readdata[fcs_pkg::RA_REWRITE_EN_BIT] = s.rewrite_en;
					n.readdata[fcs_pkg::RA_LOCK_DIS_BIT] = s.lock_dis;
					n.readdata[fcs_pkg::RA_FLASH_RUN_BIT] = s.flash_run;
					n.readdata[fcs_pkg::RA_PROG_ERR_BIT] = s.prog_err;
					n.readdata[fcs_pkg::RA_ERASE_ERR_BIT] = s.erase_err;
				end else if (req.address == fcs_pkg::REG_B_ADDR) begin
					n.readdata[fcs_pkg::RB_LOCK_RESULT_BIT] = s.lock_result;
				end else if (!req.address[fcs_pkg::REG_SEL_BIT] &&
					!req.address[0]) begin
					// A busy array cannot be read, so status stands in
					if (s.rmode == fcs_pkg::RM_STATUS || !s.rd_arr ||
						busy) begin
						n.readdata = status_word(s);
					end else begin
						n.readdata = mem_rdata;
					end
				end
			end
		end else begin
			n.rd_phase = '0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			s <= fcs_pkg::STATE_RESET;
		end else begin
			s <= n;
		end
	end
endmodule

/* verif/fcs_sequencer_properties.sv */
`timescale 1ns/10ps
module fcs_sequencer_chk (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic [fcs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [fcs_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [1:0] AVS_BYTEENABLE,
	input wire logic [fcs_pkg::DATA_W-1:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST
);
	logic acc;
	logic is_stat;
	logic rw_en;
	logic pend;
	assign acc = AVS_READ && !AVS_WAITREQUEST;
	assign is_stat = rw_en && !AVS_ADDRESS[9] && !AVS_ADDRESS[0] &&
		AVS_BYTEENABLE == 2'h3 &&
		AVS_WRITEDATA[7:0] == fcs_pkg::CMD_READ_STATUS;
	// Shadow of the rewrite enable, so a status request can be recognised
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			rw_en <= 1'b0;
			pend <= 1'b0;
		end else if (AVS_WRITE) begin
			pend <= is_stat;
			if (AVS_ADDRESS == fcs_pkg::REG_A_ADDR && AVS_BYTEENABLE[0]) begin
				rw_en <= AVS_WRITEDATA[1];
			end
		end else if (acc) begin
			pend <= 1'b0;
		end
	end
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	sequence s_rd_start;
		$rose(AVS_READ);
	endsequence
	sequence s_two_waits;
		AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST;
	endsequence
	property p_rd_wait;
		s_rd_start |-> s_two_waits;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait states wrong");
	property p_wr_nowait;
		AVS_WRITE |-> !AVS_WAITREQUEST;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait)
		else $error("write stalled");
	property p_idle_nowait;
		!AVS_READ |-> !AVS_WAITREQUEST;
	endproperty
	a_idle_nowait: assert property (p_idle_nowait)
		else $error("wait request without read");
	property p_rd_hold;
		!AVS_READ |=> $stable(AVS_READDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved while idle");
	property p_unmapped;
		acc && AVS_ADDRESS[9] && AVS_ADDRESS != fcs_pkg::REG_A_ADDR &&
			AVS_ADDRESS != fcs_pkg::REG_B_ADDR |-> AVS_READDATA == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_odd;
		acc && AVS_ADDRESS[0] |-> AVS_READDATA == 16'h0000;
	endproperty
	a_odd: assert property (p_odd)
		else $error("odd address read not zero");
	property p_lock_res;
		acc && AVS_ADDRESS == fcs_pkg::REG_B_ADDR |->
			AVS_READDATA[15:1] == 15'h0000;
	endproperty
	a_lock_res: assert property (p_lock_res)
		else $error("lock result register has stray bits");
	property p_stat_word;
		acc && pend && !AVS_ADDRESS[9] && !AVS_ADDRESS[0] |->
			(AVS_READDATA & 16'hFF4F) == 16'h0000;
	endproperty
	a_stat_word: assert property (p_stat_word)
		else $error("status word has stray bits");
endmodule
bind fcs_sequencer fcs_sequencer_chk chk_u (
	.REF_CLK(REF_CLK),
	.SRST(SRST),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST)
);

/* verif/fcs_cpu_model.sv */
`timescale 1ns/10ps
module fcs_cpu_model (
	input wire logic clk,
	input wire logic waitrequest,
	input wire logic [fcs_pkg::DATA_W-1:0] readdata,
	output fcs_pkg::fcs_bus_req_t req
);
	initial req = '0;
	// Whole 16-bit words only; callers pass even addresses, except one read at odd address 003
	task automatic xfer(input logic is_rd,
		input logic [fcs_pkg::ADDR_W-1:0] ad, input logic [15:0] d,
		input logic [1:0] be, output logic [15:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clk);
		req.read <= is_rd;
		req.write <= !is_rd;
		req.address <= ad;
		req.writedata <= d;
		req.byteenable <= be;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge clk);
			ok = (waitrequest === 1'b0);
		end
		q = readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		// Released data flips so a stale value never looks valid
		req.writedata <= ~d;
	endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/10ps
module tb;
	localparam logic [9:0] ra = fcs_pkg::REG_A_ADDR;
	localparam logic [9:0] rb = fcs_pkg::REG_B_ADDR;
	logic REF_CLK;
	logic SRST;
	fcs_pkg::fcs_bus_req_t req;
	logic [15:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	int num_errors;
	int comparisons;
	int cyc = 0;
	int seed;
	logic [15:0] mem [256];
	logic [3:0] lock;
	logic pe, ee, fr, ld, re;
	logic [9:0] a;
	fcs_cpu_model cpu_u (
		.clk(REF_CLK),
		.waitrequest(AVS_WAITREQUEST),
		.readdata(AVS_READDATA),
		.req(req)
	);
	fcs_sequencer dut_u (
		.REF_CLK(REF_CLK),
		.SRST(SRST),
		.AVS_ADDRESS(req.address),
		.AVS_READ(req.read),
		.AVS_WRITE(req.write),
		.AVS_WRITEDATA(req.writedata),
		.AVS_BYTEENABLE(req.byteenable),
		.AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST)
	);
	initial begin
		REF_CLK = 1'b0;
		// Main clock never stops, so busy-type commands are legal whenever neither error flag is set
		forever #50 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) cyc <= cyc + 1;
	function automatic logic [15:0] f_rega(input logic rdy);
		return {8'h00, ee, pe, 2'h0, fr, ld, re, rdy};
	endfunction
	function automatic logic [15:0] f_stat(input logic rdy);
		return {8'h00, rdy, 1'b0, ee, pe, 4'h0};
	endfunction
	task automatic stop_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xf(input logic r, input logic [9:0] ad,
		input logic [15:0] dw, output logic [15:0] q);
		logic ok;
		cpu_u.xfer(r, ad, dw, 2'h3, q, ok);
		if (ok !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [9:0] ad, input logic [15:0] dw);
		logic [15:0] q;
		xf(1'b0, ad, dw, q);
	endtask
	task automatic rchk(input logic [9:0] ad, input logic [15:0] e);
		logic [15:0] q;
		xf(1'b1, ad, 16'h0000, q);
		chk(q, e);
	endtask
	// Polling adds a few cycles of slack on top of the busy time
	task automatic wait_ready(input logic [9:0] ad, input int n);
		int t0;
		int k;
		logic [15:0] q;
		t0 = cyc;
		rchk(ad, f_stat(1'b0));
		q = 16'h0000;
		for (k = 0; k < 700 && q[0] !== 1'b1; k++) begin
			xf(1'b1, ra, 16'h0000, q);
		end
		if (q[0] !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		chk(16'(cyc - t0 >= n && cyc - t0 <= n + 8), 16'h0001);
	endtask
	task automatic op2(input logic [7:0] c, input logic [1:0] b, input int n);
		a = {1'b0, b, 7'h7E};
		wr(c == 8'h77 ? a : 10'h000, {8'($random(seed)), c});
		wr(a, {8'($random(seed)), 8'hD0});
		wait_ready(a, n);
	endtask
	task automatic clr();
		wr(10'h000, {8'($random(seed)), fcs_pkg::CMD_CLEAR_STATUS});
		pe = 1'b0;
		ee = 1'b0;
		rchk(ra, f_rega(1'b1));
	endtask
	task automatic prog(input logic [9:0] ad, input logic [15:0] d0,
		input logic [15:0] d1);
		logic [7:0] w;
		logic fail;
		w = ad[8:1];
		fail = (!lock[ad[8:7]] && !ld) || mem[w] !== 16'hFFFF ||
			mem[w + 8'h01] !== 16'hFFFF;
		wr(ad, {8'($random(seed)), fcs_pkg::CMD_PROGRAM});
		wr(ad, d0);
		wr(ad + 10'h002, d1);
		wait_ready(ad, int'(fcs_pkg::PROG_CYCLES));
		pe = fail;
		if (!fail) begin
			mem[w] = d0;
			mem[w + 8'h01] = d1;
		end
		rchk(ad, fr ? mem[w] : f_stat(1'b1));
		wr(ad, 16'h00FF);
		rchk(ad, mem[w]);
		rchk(ad + 10'h002, mem[w + 8'h01]);
	endtask
	task automatic blk(input logic er, input logic [1:0] b);
		if (er) begin
			op2(fcs_pkg::CMD_BLOCK_ERASE, b, int'(fcs_pkg::ERASE_CYCLES));
			ee = !lock[b] && !ld;
		end else begin
			op2(fcs_pkg::CMD_BLANK_CHECK, b, int'(fcs_pkg::BLANK_CYCLES));
			ee = !lock[b];
		end
		for (int i = 0; i < 64; i++) begin
			if (er && !ee) begin
				mem[{b, i[5:0]}] = 16'hFFFF;
			end
			ee = ee | (!er && mem[{b, i[5:0]}] !== 16'hFFFF);
		end
		lock[b] = lock[b] | (er && !ee);
		rchk(ra, f_rega(1'b1));
	endtask
	initial begin
		seed = 32'h4a70ee8c;
		num_errors = 0;
		comparisons = 0;
		SRST = 1'b1;
		{pe, ee, fr, ld, re} = 5'h00;
		lock = 4'hF;
		foreach (mem[i]) mem[i] = 16'hFFFF;
		repeat (16) @(posedge REF_CLK);
		SRST <= 1'b0;
		rchk(ra, 16'h0001);
		rchk(rb, 16'h0000);
		rchk(10'h204, 16'h0000);
		rchk(10'h003, 16'h0000);
		wr(10'h000, 16'h0070);
		rchk(10'h010, 16'hFFFF);
		re = 1'b1;
		wr(ra, 16'h0002);
		rchk(ra, f_rega(1'b1));
		wr(10'h000, {8'($random(seed)), fcs_pkg::CMD_READ_STATUS});
		rchk(10'h0A2, f_stat(1'b1));
		wr(10'h000, 16'h00FF);
		repeat (6) begin
			fr = 1'($random(seed));
			wr(ra, {12'h000, fr, 3'h2});
			a = {1'b0, 2'($random(seed)), 6'({$random(seed)} % 63), 1'b0};
			// Flash-run code is taken to live in block 0, so keep off it
			if (fr && a[8:7] == 2'h0) a[8:7] = 2'h3;
			prog(a, 16'($random(seed)), 16'($random(seed)));
			if (pe) clr();
		end
		prog(a, 16'h0000, 16'h1234);
		rchk(ra, f_rega(1'b1));
		wr(10'h000, 16'h0020);
		wr(10'h0FE, 16'h00D0);
		// The refused erase leaves a lone confirm, itself a sequence error
		pe = 1'b1;
		ee = 1'b1;
		rchk(ra, f_rega(1'b1));
		clr();
		fr = 1'b0;
		wr(ra, 16'h0002);
		op2(fcs_pkg::CMD_LOCK_PROGRAM, 2'h1, int'(fcs_pkg::LOCK_CYCLES));
		lock[1] = 1'b0;
		for (int b = 0; b < 4; b++) begin
			op2(fcs_pkg::CMD_READ_LOCK, 2'(b), int'(fcs_pkg::LOCK_READ_CYCLES));
			rchk(rb, {15'h0000, lock[b]});
		end
		prog(10'h0A0, 16'h5555, 16'hAAAA);
		clr();
		blk(1'b0, 2'h1);
		clr();
		blk(1'b0, 2'h2);
		clr();
		blk(1'b1, 2'h1);
		clr();
		ld = 1'b1;
		wr(ra, 16'h0006);
		blk(1'b1, 2'h1);
		rchk(10'h0FE, f_stat(1'b1));
		op2(fcs_pkg::CMD_READ_LOCK, 2'h1, int'(fcs_pkg::LOCK_READ_CYCLES));
		rchk(rb, 16'h0001);
		rchk(10'h0FE, 16'hFFFF);
		for (int k = 0; k < 3; k++) begin
			wr(10'h17E, {8'h00, k == 0 ? 8'h20 : k == 1 ? 8'h77 : 8'h41});
			wr(k == 2 ? 10'h182 : 10'h17E, 16'h0033);
			pe = 1'b1;
			ee = 1'b1;
			rchk(ra, f_rega(1'b1));
			clr();
		end
		wr(10'h000, 16'h0025);
		wr(10'h17E, 16'h0033);
		rchk(ra, f_rega(1'b1));
		wr(10'h000, 16'h0020);
		wr(10'h17E, 16'h00FF);
		rchk(ra, f_rega(1'b1));
		rchk(10'h17E, mem[8'hBF]);
		stop_test();
	end
endmodule
